/* hdl/adu_top.sv */
`timescale 1ns/1ns
`include "adu_params.svh"
module adu_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic i_external_master_clock_in,
  input wire logic i_frame_start,
  input wire logic i_pseudo_frame_start,
  input wire logic i_sample_strobe,
  output logic o_master_clock_out_a,
  output logic o_master_clock_out_b,
  output logic o_codec_bit_clock_a,
  output logic o_codec_bit_clock_b,
  output logic o_codec_frame_sync_a,
  output logic o_codec_frame_sync_b
);
  // programmable state
  logic [7:0] freq_hi_r [2];
  logic [7:0] freq_mid_r [2];
  logic [7:0] freq_lo_r [2];
  logic [7:0] div_ctl_r [2];
  logic [7:0] bit_div_r [2];
  logic [7:0] sync_ctl_r [2];
  logic [7:0] gen_ctl_r;
  logic [7:0] ext_div_r;
  logic [15:0] cap_cnt_r;
  logic [15:0] cap_reg_r;
  logic [15:0] smp_cnt_r;
  logic [15:0] smp_reg_r;
  logic ext_prev_r;
  logic [1:0] mst_level_r;
  logic [1:0] mst_ev_r;
  logic [1:0] skip_r;
  adu_pkg::adu_src_t src_applied_r [2];
  adu_pkg::adu_src_t src_req [2];

  // datapath between stages
  logic [1:0] load_freq;
  logic [1:0] syn_ev;
  logic [1:0] m_ev;
  logic [1:0] b_ev;
  logic [1:0] b_level;
  logic i_ev;
  logic ext_edge;
  logic frame_mark;

  // decoding shared by writes of both channels
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
    hit = (addr == target);
  endfunction

  // picks the event stream of one source
  function automatic logic pick_event(input adu_pkg::adu_src_t sel, input logic ev1,
                                      input logic ev2, input logic evx);
    case (sel)
      adu_pkg::ADU_SRC_SYNTH1: pick_event = ev1;
      adu_pkg::ADU_SRC_SYNTH2: pick_event = ev2;
      adu_pkg::ADU_SRC_EXT: pick_event = evx;
      default: pick_event = ev1;
    endcase
  endfunction

  // raw 2-bit select field to a source; the unused code 2'b10 also selects the external clock
  function automatic adu_pkg::adu_src_t to_src(input logic [1:0] raw);
    case (raw)
      2'b01: to_src = adu_pkg::ADU_SRC_SYNTH2;
      2'b10: to_src = adu_pkg::ADU_SRC_EXT;
      2'b11: to_src = adu_pkg::ADU_SRC_EXT;
      default: to_src = adu_pkg::ADU_SRC_SYNTH1;
    endcase
  endfunction

  assign frame_mark = i_frame_start | i_pseudo_frame_start;
  assign ext_edge = i_external_master_clock_in ^ ext_prev_r;

  // async mode forces both master clocks onto the external input
  always_comb begin
    if (gen_ctl_r[`ADU_CTL_ASYNC_BIT]) begin
      src_req[0] = adu_pkg::ADU_SRC_EXT;
      src_req[1] = adu_pkg::ADU_SRC_EXT;
    end else begin
      src_req[0] = to_src(gen_ctl_r[`ADU_CTL_SRC_A_LSB +: 2]);
      src_req[1] = to_src(gen_ctl_r[`ADU_CTL_SRC_B_LSB +: 2]);
    end
  end

  // both level transitions of the external pin are half-period events
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= i_external_master_clock_in;
    end
  end

  // divide-by-I on the external clock
  adu_clkdiv u_ext_div (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_event(ext_edge),
    .i_ratio(ext_div_r[3:0]),
    .o_event(i_ev),
    .o_level()
  );

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      adu_pkg::adu_sync_state_t sync_state_r;
      logic [7:0] bit_idx_r;
      logic [3:0] pulse_cnt_r;
      logic sync_out_r;
      logic bit_rise;

      // loads only on the low byte write, so a half-written value never runs
      assign load_freq[ch] = i_write &&
        hit(i_addr, (ch == 0) ? `ADU_A_S1_FREQ_LO : `ADU_A_S2_FREQ_LO);

      adu_synth u_synth (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_load(load_freq[ch]),
        .i_value({freq_hi_r[ch], freq_mid_r[ch], i_wdata}),
        .o_event(syn_ev[ch])
      );

      // divide-by-M after each synthesizer
      adu_clkdiv u_m_div (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_event(syn_ev[ch]),
        .i_ratio(div_ctl_r[ch][3:0]),
        .o_event(m_ev[ch]),
        .o_level()
      );

      // bit clock divider, ratio field + 1
      adu_clkdiv u_b_div (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_event(mst_ev_r[ch]),
        .i_ratio({1'b0, bit_div_r[ch][2:0]}),
        .o_event(b_ev[ch]),
        .o_level(b_level[ch])
      );

      assign bit_rise = b_ev[ch] & b_level[ch];

      // master clock mux; after a source change the first new event is skipped so
      // the current level lasts at least one full half-period of the new source
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          src_applied_r[ch] <= adu_pkg::ADU_SRC_SYNTH1;
          skip_r[ch] <= 1'b0;
          mst_level_r[ch] <= 1'b0;
          mst_ev_r[ch] <= 1'b0;
        end else begin
          mst_ev_r[ch] <= 1'b0;
          if (src_req[ch] != src_applied_r[ch]) begin
            src_applied_r[ch] <= src_req[ch];
            skip_r[ch] <= 1'b1;
          end else if (pick_event(src_applied_r[ch], m_ev[0], m_ev[1], i_ev)) begin
            if (skip_r[ch]) begin
              skip_r[ch] <= 1'b0;
            end else begin
              mst_level_r[ch] <= ~mst_level_r[ch];
              mst_ev_r[ch] <= 1'b1;
            end
          end
        end
      end

      // frame sync: pulse of programmed bit-clock length at frame start
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync_state_r <= adu_pkg::ADU_SYNC_IDLE;
          bit_idx_r <= 8'h00;
          pulse_cnt_r <= 4'h0;
          sync_out_r <= 1'b0;
        end else begin
          if (bit_rise) begin
            if (bit_idx_r >= `ADU_FRAME_BITS - 8'h01) begin
              bit_idx_r <= 8'h00;
            end else begin
              bit_idx_r <= bit_idx_r + 8'h01;
            end
            case (sync_state_r)
              adu_pkg::ADU_SYNC_IDLE: begin
                if (bit_idx_r == 8'h00) begin
                  sync_state_r <= adu_pkg::ADU_SYNC_PULSE;
                  pulse_cnt_r <= sync_ctl_r[ch][3:0];
                end
              end
              adu_pkg::ADU_SYNC_PULSE: begin
                if (pulse_cnt_r == 4'h0) begin
                  sync_state_r <= adu_pkg::ADU_SYNC_IDLE;
                end else begin
                  pulse_cnt_r <= pulse_cnt_r - 4'h1;
                end
              end
              default: sync_state_r <= adu_pkg::ADU_SYNC_IDLE;
            endcase
          end
          // polarity bit inverts the active level
          sync_out_r <= (sync_state_r == adu_pkg::ADU_SYNC_PULSE) ^
                        sync_ctl_r[ch][`ADU_SYNC_POL_BIT];
        end
      end

      if (ch == 0) begin : g_out_a
        assign o_codec_frame_sync_a = sync_out_r;
      end else begin : g_out_b
        assign o_codec_frame_sync_b = sync_out_r;
      end
    end
  endgenerate

  // master and bit clock outputs are flops
  assign o_master_clock_out_a = mst_level_r[0];
  assign o_master_clock_out_b = mst_level_r[1];
  assign o_codec_bit_clock_a = b_level[0];
  assign o_codec_bit_clock_b = b_level[1];

  // register writes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 2; i++) begin
        freq_hi_r[i] <= 8'(`ADU_RST_FREQ >> 16);
        freq_mid_r[i] <= 8'(`ADU_RST_FREQ >> 8);
        freq_lo_r[i] <= 8'(`ADU_RST_FREQ);
        div_ctl_r[i] <= `ADU_RST_DIV;
        bit_div_r[i] <= `ADU_RST_DIV;
        sync_ctl_r[i] <= `ADU_RST_SYNC;
      end
      gen_ctl_r <= `ADU_RST_CTL;
      ext_div_r <= `ADU_RST_DIV;
    end else if (i_write) begin
      case (i_addr)
        `ADU_A_S1_FREQ_HI: freq_hi_r[0] <= i_wdata;
        `ADU_A_S1_FREQ_MID: freq_mid_r[0] <= i_wdata;
        `ADU_A_S1_FREQ_LO: freq_lo_r[0] <= i_wdata;
        `ADU_A_S1_DIV_CTL: div_ctl_r[0] <= i_wdata;
        `ADU_A_GEN_CTL: gen_ctl_r <= i_wdata;
        `ADU_A_S2_FREQ_HI: freq_hi_r[1] <= i_wdata;
        `ADU_A_S2_FREQ_MID: freq_mid_r[1] <= i_wdata;
        `ADU_A_S2_FREQ_LO: freq_lo_r[1] <= i_wdata;
        `ADU_A_S2_DIV_CTL: div_ctl_r[1] <= i_wdata;
        `ADU_A_CP_CFG_FOUR: bit_div_r[0] <= i_wdata;
        `ADU_A_CP_RX_CFG_FOUR: bit_div_r[1] <= i_wdata;
        `ADU_A_EXT_DIV_CTL: ext_div_r <= i_wdata;
        `ADU_A_SYNC_A_CTL: sync_ctl_r[0] <= i_wdata;
        `ADU_A_SYNC_B_CTL: sync_ctl_r[1] <= i_wdata;
        default: ;
      endcase
    end
  end

  // capture counter runs on rising edges of master clock a
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_cnt_r <= 16'h0000;
    end else if (mst_ev_r[0] && mst_level_r[0]) begin
      cap_cnt_r <= cap_cnt_r + 16'h0001;
    end
  end

  // capture register holds until the next frame mark
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_reg_r <= 16'h0000;
    end else if (frame_mark) begin
      cap_reg_r <= cap_cnt_r;
    end
  end

  // sample count between frame marks; a strobe on the mark starts the next frame
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      smp_cnt_r <= 16'h0000;
      smp_reg_r <= 16'h0000;
    end else if (frame_mark) begin
      smp_reg_r <= smp_cnt_r;
      smp_cnt_r <= {15'h0000, i_sample_strobe};
    end else if (i_sample_strobe) begin
      smp_cnt_r <= smp_cnt_r + 16'h0001;
    end
  end

  // read data one cycle after the strobe, zero otherwise and for holes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_read) begin
      case (i_addr)
        `ADU_A_S1_FREQ_HI: o_rdata <= freq_hi_r[0];
        `ADU_A_S1_FREQ_MID: o_rdata <= freq_mid_r[0];
        `ADU_A_S1_FREQ_LO: o_rdata <= freq_lo_r[0];
        `ADU_A_CAP_HI: o_rdata <= cap_reg_r[15:8];
        `ADU_A_CAP_LO: o_rdata <= cap_reg_r[7:0];
        `ADU_A_S1_DIV_CTL: o_rdata <= div_ctl_r[0];
        `ADU_A_GEN_CTL: o_rdata <= gen_ctl_r;
        `ADU_A_S2_FREQ_HI: o_rdata <= freq_hi_r[1];
        `ADU_A_S2_FREQ_MID: o_rdata <= freq_mid_r[1];
        `ADU_A_S2_FREQ_LO: o_rdata <= freq_lo_r[1];
        `ADU_A_S2_DIV_CTL: o_rdata <= div_ctl_r[1];
        `ADU_A_CP_CFG_FOUR: o_rdata <= bit_div_r[0];
        `ADU_A_CP_RX_CFG_FOUR: o_rdata <= bit_div_r[1];
        `ADU_A_EXT_DIV_CTL: o_rdata <= ext_div_r;
        `ADU_A_SYNC_A_CTL: o_rdata <= sync_ctl_r[0];
        `ADU_A_SYNC_B_CTL: o_rdata <= sync_ctl_r[1];
        `ADU_A_SMP_CNT_HI: o_rdata <= smp_reg_r[15:8];
        `ADU_A_SMP_CNT_LO: o_rdata <= smp_reg_r[7:0];
        `ADU_A_STATUS: o_rdata <= {2'b00, skip_r, src_applied_r[1], src_applied_r[0]};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // adu_top

/* hdl/adu_params.svh */
`ifndef ADU_PARAMS_SVH
`define ADU_PARAMS_SVH

// register byte addresses
`define ADU_A_S1_FREQ_HI 5'h00
`define ADU_A_S1_FREQ_MID 5'h01
`define ADU_A_S1_FREQ_LO 5'h02
`define ADU_A_CAP_HI 5'h03
`define ADU_A_CAP_LO 5'h04
`define ADU_A_S1_DIV_CTL 5'h05
`define ADU_A_GEN_CTL 5'h06
`define ADU_A_S2_FREQ_HI 5'h07
`define ADU_A_S2_FREQ_MID 5'h08
`define ADU_A_S2_FREQ_LO 5'h09
`define ADU_A_S2_DIV_CTL 5'h0A
`define ADU_A_CP_CFG_FOUR 5'h0B
`define ADU_A_CP_RX_CFG_FOUR 5'h0C
`define ADU_A_EXT_DIV_CTL 5'h0D
`define ADU_A_SYNC_A_CTL 5'h0E
`define ADU_A_SYNC_B_CTL 5'h0F
`define ADU_A_SMP_CNT_HI 5'h10
`define ADU_A_SMP_CNT_LO 5'h11
`define ADU_A_STATUS 5'h12

// generator control fields
`define ADU_CTL_SRC_A_LSB 0
`define ADU_CTL_SRC_B_LSB 2
`define ADU_CTL_ASYNC_BIT 4
// sync control fields: [3:0] pulse length - 1, [4] polarity
`define ADU_SYNC_POL_BIT 4

// reset values
`define ADU_RST_FREQ 24'hC8_0000
`define ADU_RST_DIV 8'h00
`define ADU_RST_CTL 8'h00
`define ADU_RST_SYNC 8'h00

// synthesizer model: 6.18 fixed point value limits and phase step
`define ADU_N_MIN 24'h60_0000
`define ADU_N_MAX 24'hC8_0000
`define ADU_SYNTH_STEP 24'h18_0000
// bit clocks in one codec frame
`define ADU_FRAME_BITS 8'h40

`endif

/* hdl/adu_pkg.sv */
package adu_pkg;
  // master clock source selection
  typedef enum logic [1:0] {
    ADU_SRC_SYNTH1 = 2'b00,
    ADU_SRC_SYNTH2 = 2'b01,
    ADU_SRC_EXT = 2'b11
  } adu_src_t;

  // frame sync generator states
  typedef enum logic [1:0] {
    ADU_SYNC_IDLE = 2'b00,
    ADU_SYNC_PULSE = 2'b01
  } adu_sync_state_t;
endpackage

/* hdl/adu_clkdiv.sv */
`timescale 1ns/1ns
// divides a stream of half-period events by 1..16; output keeps 50% duty
module adu_clkdiv (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_event,
  input wire logic [3:0] i_ratio,
  output logic o_event,
  output logic o_level
);
  logic [3:0] count_r;
  logic [3:0] ratio_r;

  // new ratio is taken only at a half-period boundary, so no runt pulse
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= 4'h0;
      ratio_r <= 4'h0;
      o_event <= 1'b0;
      o_level <= 1'b0;
    end else begin
      o_event <= 1'b0;
      if (i_event) begin
        if (count_r >= ratio_r) begin
          count_r <= 4'h0;
          ratio_r <= i_ratio;
          o_event <= 1'b1;
          o_level <= ~o_level;
        end else begin
          count_r <= count_r + 4'h1;
        end
      end
    end
  end
endmodule // adu_clkdiv

/* hdl/adu_synth.sv */
`timescale 1ns/1ns
`include "adu_params.svh"
// fractional synthesizer model: half-period events at a rate of step/N per cycle
module adu_synth (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [23:0] i_value,
  output logic o_event
);
  logic [23:0] n_r;
  logic [24:0] acc_r;
  logic [24:0] sum;
  logic [23:0] n_clamped;

  // values outside 24..50 are held at the nearest limit
  always_comb begin
    if (i_value < `ADU_N_MIN) begin
      n_clamped = `ADU_N_MIN;
    end else if (i_value > `ADU_N_MAX) begin
      n_clamped = `ADU_N_MAX;
    end else begin
      n_clamped = i_value;
    end
  end

  assign sum = acc_r + {1'b0, `ADU_SYNTH_STEP};

  // phase accumulator; a reload keeps the phase so the output does not jump
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      n_r <= `ADU_RST_FREQ;
      acc_r <= 25'h000_0000;
      o_event <= 1'b0;
    end else begin
      if (i_load) begin
        n_r <= n_clamped;
      end
      if (sum >= {1'b0, n_r}) begin
        acc_r <= sum - {1'b0, n_r};
        o_event <= 1'b1;
      end else begin
        acc_r <= sum;
        o_event <= 1'b0;
      end
    end
  end
endmodule // adu_synth

/* dv/adu_top_asserts.sv */
`timescale 1ns/1ns
`include "adu_params.svh"
// port-level checks on the register port and the clock pins
module adu_top_asserts (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic i_frame_start,
  input wire logic i_pseudo_frame_start,
  input wire logic o_master_clock_out_a,
  input wire logic o_master_clock_out_b,
  input wire logic o_codec_bit_clock_a
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic fm;
  // either frame mark may move the capture register
  assign fm = i_frame_start | i_pseudo_frame_start;
  rdata_idle_a: assert property (!i_read |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (i_read && i_addr > `ADU_A_STATUS |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  freq_echo_a: assert property (i_write && i_addr == `ADU_A_S1_FREQ_HI ##1
    i_read && i_addr == `ADU_A_S1_FREQ_HI |=> o_rdata == $past(i_wdata, 2))
    else $error("frequency byte not read back");
  cap_hold_a: assert property ((!fm && i_read && i_addr == `ADU_A_CAP_LO) ##1 !fm
    ##1 (i_read && i_addr == `ADU_A_CAP_LO) |=> o_rdata == $past(o_rdata, 2))
    else $error("capture moved without a frame mark");
  // no source reaches the pins faster than three cycles per half period
  clka_high_a: assert property ($rose(o_master_clock_out_a) |=> o_master_clock_out_a[*2])
    else $error("short high on master clock a");
  clka_low_a: assert property ($fell(o_master_clock_out_a) |=> !o_master_clock_out_a[*2])
    else $error("short low on master clock a");
  clkb_high_a: assert property ($rose(o_master_clock_out_b) |=> o_master_clock_out_b[*2])
    else $error("short high on master clock b");
  bitclk_low_a: assert property ($fell(o_codec_bit_clock_a) |=> !o_codec_bit_clock_a[*2])
    else $error("short low on bit clock a");
endmodule // adu_top_asserts

/* dv/adu_codec_model.sv */
`timescale 1ns/1ns
// codec side: tallies clock edges and sync time, and runs the external oscillator
module adu_codec_model (
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic i_mclk_a,
  input wire logic i_mclk_b,
  input wire logic i_bclk_a,
  input wire logic i_sync_a,
  input wire logic i_bclk_b,
  input wire logic i_sync_b,
  output logic o_ext_clock,
  output int o_rise_a,
  output int o_rise_b,
  output int o_rise_bit,
  output int o_sync_high,
  output int o_high_a,
  output int o_rise_bit_b,
  output int o_sync_high_b
);
  logic pa, pb, pt, pu;
  int ph;
  initial begin
    o_ext_clock = 1'b0;
    ph = 0;
  end
  // oscillator runs free, half period three cycles, kept at the runt limit
  always @(posedge i_clock) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2)
      o_ext_clock <= ~o_ext_clock;
  end
  // tallies restart on clear so each window stands alone
  always @(posedge i_clock) begin
    pa <= i_mclk_a;
    pb <= i_mclk_b;
    pt <= i_bclk_a;
    pu <= i_bclk_b;
    if (i_clear) begin
      o_rise_a <= 0;
      o_rise_b <= 0;
      o_rise_bit <= 0;
      o_sync_high <= 0;
      o_high_a <= 0;
      o_rise_bit_b <= 0;
      o_sync_high_b <= 0;
    end else begin
      o_rise_bit_b <= o_rise_bit_b + int'(i_bclk_b & ~pu);
      o_sync_high_b <= o_sync_high_b + int'(i_sync_b);
      o_rise_a <= o_rise_a + int'(i_mclk_a & ~pa);
      o_rise_b <= o_rise_b + int'(i_mclk_b & ~pb);
      o_rise_bit <= o_rise_bit + int'(i_bclk_a & ~pt);
      o_sync_high <= o_sync_high + int'(i_sync_a);
      o_high_a <= o_high_a + int'(i_mclk_a);
    end
  end
endmodule // adu_codec_model

/* dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0, i_read = 1'b0, fs = 1'b0, pfs = 1'b0, smp = 1'b0, clr = 1'b0;
  logic [7:0] o_rdata, h, l;
  logic ext, ma, mb, ba, bb, sa, sb;
  logic [15:0] c1;
  int ra, rb, rbit, sh, ha, rbb, shb, fails = 0, checks_done = 0;
  int dv[3] = '{0, 1, 15};

  // 20 MHz
  always #25 i_clock = ~i_clock;

  adu_top dut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
    .i_external_master_clock_in(ext), .i_frame_start(fs), .i_pseudo_frame_start(pfs),
    .i_sample_strobe(smp), .o_master_clock_out_a(ma), .o_master_clock_out_b(mb),
    .o_codec_bit_clock_a(ba), .o_codec_bit_clock_b(bb), .o_codec_frame_sync_a(sa),
    .o_codec_frame_sync_b(sb));
  adu_codec_model codec (.i_clock, .i_clear(clr), .i_mclk_a(ma), .i_mclk_b(mb),
    .i_bclk_a(ba), .i_sync_a(sa), .i_bclk_b(bb), .i_sync_b(sb), .o_ext_clock(ext),
    .o_rise_a(ra), .o_rise_b(rb), .o_rise_bit(rbit), .o_sync_high(sh), .o_high_a(ha),
    .o_rise_bit_b(rbb), .o_sync_high_b(shb));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic near(input int s, input int e, input int t);
    check((s >= e - t && s <= e + t) ? e : s, e);
  endtask
  // a write strobe stays up until the next task takes the bus, so writes run back to
  // back; a read drops its strobe after one edge so the data cycle is not read again
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_write <= 1'b1;
    i_read <= 1'b0;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    i_read <= 1'b1;
    i_write <= 1'b0;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(negedge i_clock);
    v = o_rdata;
    @(posedge i_clock);
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(v, e);
  endtask
  task automatic idle(input int n);
    i_write <= 1'b0;
    i_read <= 1'b0;
    repeat (n) @(posedge i_clock);
  endtask
  // settle after a change, then count over 2048 cycles
  task automatic meas();
    idle(256);
    clr <= 1'b1;
    @(posedge i_clock);
    clr <= 1'b0;
    repeat (2047) @(posedge i_clock);
  endtask
  task automatic mark(input logic p);
    idle(0);
    fs <= ~p;
    pfs <= p;
    @(posedge i_clock);
    fs <= 1'b0;
    pfs <= 1'b0;
  endtask
  // upper bytes first, low byte last so the load is consistent
  task automatic prog(input logic [4:0] b, input logic [23:0] n);
    wr(b, n[23:16]);
    wr(b + 5'h01, n[15:8]);
    wr(b + 5'h02, n[7:0]);
  endtask
  // master rises in 2048 cycles: synth clock is N/3 cycles per period
  function automatic int rate(input logic [23:0] n, input int d);
    return int'((64'd6144 << 18) / n / (d + 1));
  endfunction

  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    for (int a = 0; a < 11; a++) begin
      if (a != 3 && a != 4)
        rc(5'(a), (a == 0 || a == 7) ? 8'hC8 : 8'h00);
    end
    wr(5'h1F, 8'hFF);
    rc(5'h1F, 8'h00);
    meas();
    near(ra, rate(24'hC8_0000, 0), 2);
    wr(5'h01, 8'h00);
    wr(5'h00, 8'h62);
    rc(5'h00, 8'h62);
    meas();
    near(ra, rate(24'hC8_0000, 0), 2);
    wr(5'h02, 8'h00);
    meas();
    near(ra, rate(24'h62_0000, 0), 2);
    prog(5'h00, 24'h60_0000);
    foreach (dv[i]) begin
      wr(5'h05, 8'(dv[i]));
      meas();
      near(ra, rate(24'h60_0000, dv[i]), 2);
      near(ha, 1024, 2);
    end
    prog(5'h07, 24'h90_0000);
    wr(5'h06, 8'h04);
    wr(5'h0B, 8'h03);
    wr(5'h0C, 8'h01);
    wr(5'h05, 8'h00);
    meas();
    near(ra, rate(24'h60_0000, 0), 2);
    near(rb, rate(24'h90_0000, 0), 2);
    near(rbit, rate(24'h60_0000, 3), 2);
    near(rbb, rate(24'h90_0000, 1), 2);
    // both master clocks on synth 1 with bit ratio 4, so each frame is 2048 cycles
    wr(5'h06, 8'h00);
    wr(5'h0C, 8'h03);
    for (int p = 0; p < 2; p++) begin
      wr(5'h0E, p ? 8'h13 : 8'h03);
      wr(5'h0F, p ? 8'h13 : 8'h03);
      meas();
      near(sh, p ? 1920 : 128, 3);
      near(shb, p ? 1920 : 128, 3);
    end
    for (int i = 0; i < 2; i++) begin
      wr(5'h0D, 8'(i));
      wr(5'h06, 8'h03);
      meas();
      near(ra, 2048 / (6 * (i + 1)), 2);
    end
    wr(5'h0D, 8'h00);
    wr(5'h06, 8'h10);
    meas();
    near(rb, 341, 2);
    // marks 1600 cycles apart; capture follows the source of master clock a only
    for (int k = 0; k < 3; k++) begin
      wr(5'h06, k == 2 ? 8'h03 : 8'(k));
      idle(64);
      mark(1'b0);
      idle(4);
      rd(5'h03, h);
      rd(5'h04, l);
      c1 = {h, l};
      idle(1591);
      mark(1'b1);
      idle(4);
      rd(5'h03, h);
      rd(5'h04, l);
      rc(5'h04, l);
      near(int'(16'({h, l} - c1)), 1600 / (k == 0 ? 8 : k == 1 ? 12 : 6), 2);
    end
    mark(1'b0);
    repeat (5) begin
      smp <= 1'b1;
      @(posedge i_clock);
      smp <= 1'b0;
      @(posedge i_clock);
    end
    mark(1'b1);
    idle(2);
    rc(5'h10, 8'h00);
    rc(5'h11, 8'h05);
    finish_test();
  end

  // the run needs about 33000 cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    fails++;
    finish_test();
  end
endmodule // tb_top

bind adu_top adu_top_asserts chk (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_write,
  .i_read, .o_rdata, .i_frame_start, .i_pseudo_frame_start, .o_master_clock_out_a,
  .o_master_clock_out_b, .o_codec_bit_clock_a);
